// >>> dsr_device.sv
// converter end: conversion timing, end of conversion flag, result shifter
// assumes the host keeps the link protocol; sample words come from the user side
`include "dsr_cfg.svh"
module dsr_device #(
   parameter int unsigned CONV_CYCLES = 10000,
   parameter int unsigned EXT_CONV_PERIODS = `DSR_EXT_CONV_PERIODS
) (
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   dsr_link_if.device link,
   // configuration
   input wire logic notch_select_pin_i,
   input wire logic dual_variant_i,
   input wire logic ext_clock_mode_i,
   input wire logic external_conversion_clock_i,
   // user side
   input wire logic [`DSR_RESULT_BITS-1:0] sample_i,
   output dsr_pkg::dsr_mode_type mode_o,
   output logic sample_tick_o,
   output logic conv_done_o,
   output logic [31:0] modulator_sample_freq_o,
   output logic [31:0] filter_notch_freq_o,
   output logic [31:0] max_output_rate_o
);
   import dsr_pkg::*;

   dsr_dev_state_type state_reg;
   logic [31:0] conv_cnt_reg;
   logic [3:0] div_cnt_reg;
   logic ext_d_reg;
   logic sck_d_reg;
   logic [`DSR_WORD_BITS-1:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic sdo_reg;
   logic ext_rise;
   logic sck_fall;
   logic conv_step;

   ////////////////////////////////////////////////////////////////////////
   // mode and frequency reporting
   always_comb begin
      if (ext_clock_mode_i) begin
         mode_o = DSR_MODE_EXT;
      end else if (dual_variant_i) begin
         mode_o = DSR_MODE_INT_DUAL;
      end else if (notch_select_pin_i) begin
         mode_o = DSR_MODE_INT_50;
      end else begin
         mode_o = DSR_MODE_INT_60;
      end
   end

   // external frequency unknown here; reported as zero in that mode
   always_comb begin
      case (mode_o)
         DSR_MODE_INT_50: modulator_sample_freq_o = 32'(`DSR_FS_50HZ);
         DSR_MODE_INT_DUAL: modulator_sample_freq_o = 32'(`DSR_FS_DUAL);
         DSR_MODE_INT_60: modulator_sample_freq_o = 32'(`DSR_FS_60HZ);
         default: modulator_sample_freq_o = 32'h0;
      endcase
      filter_notch_freq_o = modulator_sample_freq_o / `DSR_SAMPLE_PER_NOTCH;
      max_output_rate_o = modulator_sample_freq_o / `DSR_SAMPLE_PER_OUTMAX;
   end

   ////////////////////////////////////////////////////////////////////////
   // external clock edges, already synchronous per board assumption
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ext_d_reg <= 1'b0;
      end else begin
         ext_d_reg <= external_conversion_clock_i;
      end
   end
   assign ext_rise = external_conversion_clock_i & ~ext_d_reg;

   // modulator sample tick: every tenth external edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         div_cnt_reg <= 4'h0;
         sample_tick_o <= 1'b0;
      end else begin
         sample_tick_o <= 1'b0;
         if (ext_clock_mode_i && ext_rise) begin
            if (div_cnt_reg == 4'(`DSR_EXT_DIV - 1)) begin
               div_cnt_reg <= 4'h0;
               sample_tick_o <= 1'b1;
            end else begin
               div_cnt_reg <= div_cnt_reg + 4'h1;
            end
         end
      end
   end

   // external mode counts external conversion clock rising edges, internal mode system cycles
   assign conv_step = ext_clock_mode_i ? ext_rise : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // link serial clock edges
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sck_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= link.sck;
      end
   end
   assign sck_fall = ~link.sck & sck_d_reg;

   ////////////////////////////////////////////////////////////////////////
   // conversion and readout sequence
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= DSR_DEV_CONV;
         conv_cnt_reg <= 32'h0;
         bit_cnt_reg <= 5'h0;
         shift_reg <= '0;
         conv_done_o <= 1'b0;
      end else begin
         conv_done_o <= 1'b0;
         case (state_reg)
            DSR_DEV_CONV: begin
               if (conv_step) begin
                  if (conv_cnt_reg >= (ext_clock_mode_i ? EXT_CONV_PERIODS - 1
                                       : CONV_CYCLES - 1)) begin
                     conv_cnt_reg <= 32'h0;
                     // top nibble 0010: end flag and dummy zero, sign bit set, range bit zero; result below
                     shift_reg <= {4'h2, sample_i};
                     conv_done_o <= 1'b1;
                     state_reg <= DSR_DEV_READY;
                  end else begin
                     conv_cnt_reg <= conv_cnt_reg + 32'h1;
                  end
               end
            end
            DSR_DEV_READY: begin
               bit_cnt_reg <= 5'h0;
               if (!link.cs_n) begin
                  state_reg <= DSR_DEV_SHIFT;
               end
            end
            DSR_DEV_SHIFT: begin
               if (link.cs_n) begin
                  state_reg <= DSR_DEV_CONV;
               end else if (sck_fall) begin
                  if (bit_cnt_reg == 5'(`DSR_WORD_BITS - 1)) begin
                     state_reg <= DSR_DEV_CONV;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h1;
                     shift_reg <= {shift_reg[`DSR_WORD_BITS-2:0], 1'b0};
                  end
               end
            end
            default: state_reg <= DSR_DEV_CONV;
         endcase
      end
   end

   // busy shows high; ready presents msb low-going end of conversion
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sdo_reg <= 1'b1;
      end else if (link.cs_n) begin
         sdo_reg <= 1'b1;
      end else if (state_reg == DSR_DEV_CONV) begin
         sdo_reg <= 1'b1;
      end else begin
         sdo_reg <= shift_reg[`DSR_WORD_BITS-1];
      end
   end
   assign link.sdo = sdo_reg;
endmodule

// >>> dsr_cfg.svh
// timing and framing constants for the serial result readout
// assumes a 100 MHz system clock shared by both ends
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH
`define DSR_CLK_HZ 100000000
`define DSR_SAMPLE_PER_NOTCH 256
`define DSR_SAMPLE_PER_OUTMAX 1024
`define DSR_EXT_DIV 10
`define DSR_EXT_CONV_PERIODS 10278
`define DSR_FS_50HZ 12800
`define DSR_FS_60HZ 15360
`define DSR_FS_DUAL 13980
`define DSR_WORD_BITS 24
`define DSR_SCK_HALF 4
`define DSR_RESULT_BITS 20
`endif

// >>> dsr_pkg.sv
// types shared by both ends of the result readout
// assumes dsr_cfg.svh is on the include path
package dsr_pkg;
   typedef enum logic [1:0] {
      DSR_MODE_INT_60 = 2'h0,
      DSR_MODE_INT_50 = 2'h1,
      DSR_MODE_INT_DUAL = 2'h2,
      DSR_MODE_EXT = 2'h3
   } dsr_mode_type;
   typedef enum logic [1:0] {
      DSR_DEV_CONV = 2'h0,
      DSR_DEV_READY = 2'h1,
      DSR_DEV_SHIFT = 2'h2
   } dsr_dev_state_type;
   typedef enum logic [2:0] {
      DSR_HOST_IDLE = 3'h0,
      DSR_HOST_WAIT = 3'h1,
      DSR_HOST_LOW = 3'h2,
      DSR_HOST_HIGH = 3'h3,
      DSR_HOST_DONE = 3'h4
   } dsr_host_state_type;
endpackage

// >>> dsr_link_if.sv
// three wire readout link: chip select, serial clock, serial data out
// assumes one clock for both ends
interface dsr_link_if;
   logic cs_n;
   logic sck;
   logic sdo;
   modport device (input cs_n, input sck, output sdo);
   modport host (output cs_n, output sck, input sdo);
endinterface

// >>> dsr_host.sv
// host end: serial master reading 24-bit words with timeout and averaging
// assumes the device end keeps the link protocol
`include "dsr_cfg.svh"
module dsr_host #(
   parameter int unsigned TIMEOUT_CYCLES = 20000
) (
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   dsr_link_if.host link,
   // user side
   input wire logic start_i,
   input wire logic avg_enable_i,
   output logic busy_o,
   output logic word_valid_o,
   output logic [`DSR_WORD_BITS-1:0] word_o,
   output logic timeout_o
);
   import dsr_pkg::*;

   dsr_host_state_type state_reg;
   logic [31:0] wait_cnt_reg;
   logic [2:0] half_cnt_reg;
   logic [4:0] bit_cnt_reg;
   logic [`DSR_WORD_BITS-1:0] rx_reg;
   logic [`DSR_WORD_BITS-1:0] prev_reg;
   logic have_prev_reg;
   logic cs_n_reg;
   logic sck_reg;
   logic [`DSR_WORD_BITS:0] sum;

   assign link.cs_n = cs_n_reg;
   assign link.sck = sck_reg;
   assign busy_o = (state_reg != DSR_HOST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= DSR_HOST_IDLE;
         cs_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         wait_cnt_reg <= 32'h0;
         half_cnt_reg <= 3'h0;
         bit_cnt_reg <= 5'h0;
         rx_reg <= '0;
         timeout_o <= 1'b0;
      end else begin
         timeout_o <= 1'b0;
         case (state_reg)
            DSR_HOST_IDLE: begin
               sck_reg <= 1'b0;
               if (start_i) begin
                  cs_n_reg <= 1'b0;
                  wait_cnt_reg <= 32'h0;
                  state_reg <= DSR_HOST_WAIT;
               end
            end
            DSR_HOST_WAIT: begin
               // one cycle guard lets the device see select before sdo is trusted
               if (!link.sdo && wait_cnt_reg != 32'h0) begin
                  bit_cnt_reg <= 5'h0;
                  half_cnt_reg <= 3'h0;
                  state_reg <= DSR_HOST_LOW;
               end else if (wait_cnt_reg >= TIMEOUT_CYCLES - 1) begin
                  cs_n_reg <= 1'b1;
                  timeout_o <= 1'b1;
                  state_reg <= DSR_HOST_IDLE;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg + 32'h1;
               end
            end
            DSR_HOST_LOW: begin
               if (half_cnt_reg == 3'(`DSR_SCK_HALF - 1)) begin
                  half_cnt_reg <= 3'h0;
                  sck_reg <= 1'b1;
                  rx_reg <= {rx_reg[`DSR_WORD_BITS-2:0], link.sdo};
                  state_reg <= DSR_HOST_HIGH;
               end else begin
                  half_cnt_reg <= half_cnt_reg + 3'h1;
               end
            end
            DSR_HOST_HIGH: begin
               if (half_cnt_reg == 3'(`DSR_SCK_HALF - 1)) begin
                  half_cnt_reg <= 3'h0;
                  sck_reg <= 1'b0;
                  if (bit_cnt_reg == 5'(`DSR_WORD_BITS - 1)) begin
                     state_reg <= DSR_HOST_DONE;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h1;
                     state_reg <= DSR_HOST_LOW;
                  end
               end else begin
                  half_cnt_reg <= half_cnt_reg + 3'h1;
               end
            end
            DSR_HOST_DONE: begin
               cs_n_reg <= 1'b1;
               state_reg <= DSR_HOST_IDLE;
            end
            default: state_reg <= DSR_HOST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // optional two-sample running average keeps one result per word
   assign sum = {1'b0, prev_reg} + {1'b0, rx_reg};

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         word_valid_o <= 1'b0;
         word_o <= '0;
         prev_reg <= '0;
         have_prev_reg <= 1'b0;
      end else begin
         word_valid_o <= 1'b0;
         if (state_reg == DSR_HOST_DONE) begin
            prev_reg <= rx_reg;
            have_prev_reg <= 1'b1;
            word_valid_o <= 1'b1;
            if (avg_enable_i && have_prev_reg) begin
               word_o <= sum[`DSR_WORD_BITS:1];
            end else begin
               word_o <= rx_reg;
            end
         end
      end
   end
endmodule

// >>> dsr_link_asserts.sv
// checker for the three wire readout link between host and device
// assumes one clock, reset synchronous active high, both ends joined by dsr_link_if
module dsr_link_asserts (
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdo_i
);
   logic sck_d_reg;
   logic eoc_seen_reg;
   logic [4:0] rise_cnt_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      sck_d_reg <= sck_i;
   end
   // both trackers forget everything when select goes high
   always_ff @(posedge clk_i) begin
      if (reset_i || cs_n_i) begin
         rise_cnt_reg <= 5'h00;
      end else if (sck_i && !sck_d_reg) begin
         rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i || cs_n_i) begin
         eoc_seen_reg <= 1'b0;
      end else if (!sdo_i) begin
         eoc_seen_reg <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_sck_idle; cs_n_i |-> !sck_i; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock not low while deselected");
   property p_busy_desel; cs_n_i && $past(cs_n_i, 3) |-> sdo_i; endproperty
   a_busy_desel: assert property (p_busy_desel) else $error("data low while deselected");
   property p_high_len; $rose(sck_i) |-> sck_i[*4] ##1 !sck_i; endproperty
   a_high_len: assert property (p_high_len) else $error("clock high phase length wrong");
   property p_low_len; $fell(sck_i) |-> !sck_i[*4]; endproperty
   a_low_len: assert property (p_low_len) else $error("clock low phase too short");
   property p_stable_high; sck_i && !cs_n_i |-> $stable(sdo_i); endproperty
   a_stable_high: assert property (p_stable_high) else $error("data moved while clock high");
   property p_clk_after_eoc; $rose(sck_i) |-> eoc_seen_reg; endproperty
   a_clk_after_eoc: assert property (p_clk_after_eoc) else $error("clocked before end flag");
   property p_eoc_msb; eoc_seen_reg && !cs_n_i && rise_cnt_reg == 5'h00 |-> !sdo_i; endproperty
   a_eoc_msb: assert property (p_eoc_msb) else $error("end flag not held to first clock");
   property p_sel_first; $fell(cs_n_i) |-> sdo_i; endproperty
   a_sel_first: assert property (p_sel_first) else $error("data low in select cycle");
   property p_word_len; $rose(cs_n_i) |-> rise_cnt_reg == 5'h18 || rise_cnt_reg == 5'h00; endproperty
   a_word_len: assert property (p_word_len) else $error("word not 24 clocks long");
   property p_restart; $fell(sck_i) && rise_cnt_reg == 5'h18 |-> ##[1:3] sdo_i; endproperty
   a_restart: assert property (p_restart) else $error("no busy after last bit");
endmodule

// >>> delta_sigma_adc_serial_readout_tb.sv
// self-checking bench: host and device ends joined over the link
// assumes shortened conversion and timeout counts set through parameters
module delta_sigma_adc_serial_readout_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dsr_pkg::*;
   logic clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, avg_enable_i = 1'b0;
   logic notch_i = 1'b0, dual_i = 1'b0, ext_i = 1'b0, eclk_i = 1'b0, sck_q = 1'b0;
   logic [19:0] sample_i = 20'h00000;
   logic [23:0] mon_word = 24'h000000;
   logic [23:0] word_o;
   logic [31:0] fs_o, notch_o, max_o;
   logic busy_o, word_valid_o, timeout_o, tick_o, done_w;
   logic eclk_q = 1'b0;
   // conversion clock edges counted since the last delivered word
   int dones = 0, erise = 0, conv_len = 0;
   dsr_mode_type mode_o;
   int fails = 0, cmp_count = 0, ticks = 0, n;
   int fs_tab [4] = '{15360, 12800, 13980, 0};
   logic [2:0] pin_tab [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
   dsr_link_if link();
   dsr_device #(.CONV_CYCLES(50), .EXT_CONV_PERIODS(20)) dsr_device_i (.clk_i(clk_i),
      .reset_i(reset_i), .link(link), .notch_select_pin_i(notch_i), .dual_variant_i(dual_i),
      .ext_clock_mode_i(ext_i), .external_conversion_clock_i(eclk_i), .sample_i(sample_i),
      .mode_o(mode_o), .sample_tick_o(tick_o), .conv_done_o(done_w),
      .modulator_sample_freq_o(fs_o), .filter_notch_freq_o(notch_o),
      .max_output_rate_o(max_o));
   dsr_host #(.TIMEOUT_CYCLES(200)) dsr_host_i (.clk_i(clk_i), .reset_i(reset_i),
      .link(link), .start_i(start_i), .avg_enable_i(avg_enable_i), .busy_o(busy_o),
      .word_valid_o(word_valid_o), .word_o(word_o), .timeout_o(timeout_o));
   dsr_link_asserts dsr_link_asserts_i (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(link.cs_n),
      .sck_i(link.sck), .sdo_i(link.sdo));
   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   // wire side monitor: bits taken on rising clock, as the host should
   always @(posedge clk_i) begin
      sck_q <= link.sck;
      if (link.sck && !sck_q) begin
         mon_word <= {mon_word[22:0], link.sdo};
      end
      if (tick_o === 1'b1) begin
         ticks++;
      end
      eclk_q <= eclk_i;
      if (word_valid_o === 1'b1) begin
         erise = 0;
      end
      if (eclk_i && !eclk_q) begin
         erise++;
      end
      if (done_w === 1'b1) begin
         dones++;
         conv_len = erise;
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic pulse_start;
      @(posedge clk_i) start_i <= 1'b1;
      @(posedge clk_i) start_i <= 1'b0;
      @(negedge clk_i);
      check("cs_n", 32'h0, 32'(link.cs_n));
      check("busy_o", 32'h1, 32'(busy_o));
   endtask
   task automatic read_word(input logic [23:0] wire_exp, input logic [23:0] out_exp);
      int d0;
      d0 = dones;
      pulse_start();
      n = 0;
      while (word_valid_o !== 1'b1 && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      check("word_valid_o", 32'h1, 32'(word_valid_o));
      check("word_o", 32'(out_exp), 32'(word_o));
      check("wire_word", 32'(wire_exp), 32'(mon_word));
      check("cs_n_after", 32'h1, 32'(link.cs_n));
      check("busy_o_done", 32'h0, 32'(busy_o));
      check("conv_done", 32'(d0 + 1), 32'(dones));
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      check("idle_link", 32'h5, 32'({link.cs_n, link.sck, link.sdo}));
      // mode table: select, dual, external clock
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i) {notch_i, dual_i, ext_i} <= pin_tab[k];
         @(negedge clk_i);
         check("mode_o", 32'(k), 32'(mode_o));
         check("fs", fs_tab[k], fs_o);
         check("notch", fs_tab[k] / 256, notch_o);
         check("max_rate", fs_tab[k] / 1024, max_o);
      end
      @(posedge clk_i) {notch_i, dual_i, ext_i, sample_i} <= {3'h0, 20'h12345};
      read_word(24'h212345, 24'h212345);
      @(posedge clk_i) {avg_enable_i, sample_i} <= {1'b1, 20'h0ABCD};
      read_word(24'h20ABCD, 24'h20E789);
      @(posedge clk_i) sample_i <= 20'h00010;
      read_word(24'h200010, 24'h2055EE);
      // external mode with a silent conversion clock never ends conversion
      @(posedge clk_i) {avg_enable_i, ext_i} <= 2'h1;
      pulse_start();
      n = 0;
      while (timeout_o !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      check("timeout_o", 32'h1, 32'(timeout_o));
      @(negedge clk_i);
      check("cs_n_timeout", 32'h1, 32'(link.cs_n));
      // 100 rising conversion clock edges, 6 system cycles each
      fork
         repeat (100) begin
            @(posedge clk_i) eclk_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            eclk_i <= 1'b0;
            repeat (2) @(posedge clk_i);
         end
      join_none
      @(posedge clk_i) sample_i <= 20'h54321;
      read_word(24'h254321, 24'h254321);
      repeat (700) @(posedge clk_i);
      check("sample_ticks", 32'h0000000A, 32'(ticks));
      check("conv_len", 32'h00000014, 32'(conv_len));
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      tally_and_finish();
   end
endmodule
